/* logic/angle_gain_offset_linearizer.sv */
// Angle gain, post-gain offset and transfer curve with an APB register slave
//
// Function
// RULE_01: Input angle is multiplied by an unsigned 6.10 gain; zero gain gives zero.
// RULE_02: Without gain clamp the gained angle wraps modulo a full turn.
// RULE_03: With gain clamp, output saturates to top code, then zero past wrap point.
// RULE_04: Wrap point is an 8-bit code compared against the pre-gain angle.
// RULE_05: Software should place the wrap point at half turn plus half turn over gain.
// RULE_06: Software must set the wrap point above a full turn over gain.
// RULE_07: Reset gives gain clamp on, wrap point zero, offset clamp on.
// RULE_08: Signed offset of two codes per step, wrapped or clamped to range.
// RULE_09: Two-bit mode picks fixed or variable, linearization or binning.
// RULE_10: Fixed linearization uses 2 to 33 equally spaced signed corrections.
// RULE_11: Span select scales corrections to 45, 90, 180 or 360 degrees.
// RULE_12: Falling as well as rising transfer curves are allowed.
// RULE_13: Linearization results outside a full turn stick at the nearest end.
// RULE_14: Rotary use needs zero correction at both curve endpoints.
// RULE_15: Fixed binning outputs the unsigned 13-bit value of the bin below.
// RULE_16: Binning ignores span select and takes values in any order.
// RULE_17: Variable linearization uses 2 to 22 points at programmed positions.
// RULE_18: Curve input positions are 6-bit codes of 1024 angle codes each.
// RULE_19: Software must program positions in non-decreasing order.
// RULE_20: Below the first position the first segment's slope is extended.
// RULE_21: Above the last position the last segment's slope is extended.
// RULE_22: Angles are 16-bit codes for a full turn, half turn is 32768.
// RULE_23: The three stages run per sample and the result is registered once.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "angle_curve_map.svh"
module angle_gain_offset_linearizer
  import angle_curve_pkg::*;
(
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic [15:0] pre_scale_angle,
  input  wire  logic        sample_valid,
  output logic       [15:0] result_angle,
  output logic              result_valid
);
  // ==========================================================
  // Configuration and table storage
  logic        scale_clamp_r;
  logic        offset_clamp_r;
  logic [1:0]  mode_r;
  logic [1:0]  span_r;
  logic [5:0]  count_r;
  logic [15:0] gain_r;
  logic [7:0]  wrap_r;
  logic [15:0] offset_r;
  ytab_t       ytab_r;
  xtab_t       xtab_r;
  cfg_t        cfg;
  logic [31:0] prdata_r;
  logic [15:0] result_r;
  logic        result_valid_r;

  assign cfg = '{scale_clamp_enable:     scale_clamp_r,
                 offset_clamp_enable:    offset_clamp_r,
                 mode:                   curve_mode_t'(mode_r),
                 correction_span_select: span_r,
                 point_count:            count_r,
                 angle_scale_factor:     gain_r,
                 clamp_wrap_point:       wrap_r,
                 post_scale_offset:      offset_r};

  // ==========================================================
  // APB decode; zero wait states, unmapped access flags an error
  logic        setup;
  logic        access;
  logic        wr_en;
  logic [5:0]  tab_idx;
  logic        hit_ctrl;
  logic        hit_gain;
  logic        hit_wrap;
  logic        hit_offs;
  logic        hit_res;
  logic        hit_y;
  logic        hit_x;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_word;

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign tab_idx  = paddr[7:2];
  assign hit_ctrl = paddr == `OFF_CTRL;
  assign hit_gain = paddr == `OFF_GAIN;
  assign hit_wrap = paddr == `OFF_WRAP;
  assign hit_offs = paddr == `OFF_OFFSET;
  assign hit_res  = paddr == `OFF_RESULT;
  assign hit_y    = (paddr[11:8] == `PAGE_YTAB) && (paddr[1:0] == 2'h0) &&
                    (tab_idx < 6'(`Y_POINTS));
  assign hit_x    = (paddr[11:8] == `PAGE_XTAB) && (paddr[1:0] == 2'h0) &&
                    (tab_idx < 6'(`X_POINTS));
  assign mapped   = hit_ctrl || hit_gain || hit_wrap || hit_offs || hit_res || hit_y || hit_x;
  assign pready   = 1'b1;
  assign pslverr  = access && !mapped;
  // Result register is read only, a write there is simply dropped
  assign wr_en    = access && pwrite && mapped;
  assign prdata   = prdata_r;

  // Y reads keep all six index bits, entry 32 needs the top one
  assign ctrl_word = {20'h0, count_r, span_r, mode_r, offset_clamp_r, scale_clamp_r};
  assign rd_mux    = hit_ctrl ? ctrl_word                       :
                     hit_gain ? {16'h0, gain_r}                 :
                     hit_wrap ? {24'h0, wrap_r}                 :
                     hit_offs ? {16'h0, offset_r}               :
                     hit_res  ? {16'h0, result_r}               :
                     hit_y    ? {19'h0, ytab_r[tab_idx]}        :
                     hit_x    ? {26'h0, xtab_r[5'(tab_idx)]}    : 32'h0;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (setup) begin
      prdata_r <= rd_mux;
    end
  end

  // ==========================================================
  // Scalar configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scale_clamp_r  <= `RST_SCALE_CLAMP;   // RULE_07
      offset_clamp_r <= `RST_OFFS_CLAMP;    // RULE_07
      mode_r         <= 2'h0;
      span_r         <= `RST_SPAN;
      count_r        <= `RST_COUNT;
      gain_r         <= `RST_GAIN;
      wrap_r         <= `RST_WRAP;          // RULE_07
      offset_r       <= `RST_OFFSET;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        scale_clamp_r  <= pwdata[`CTRL_SCALE_CLAMP];
        offset_clamp_r <= pwdata[`CTRL_OFFS_CLAMP];
        mode_r         <= pwdata[`CTRL_MODE_LO +: 2];   // RULE_09
        span_r         <= pwdata[`CTRL_SPAN_LO +: 2];   // RULE_11
        count_r        <= pwdata[`CTRL_COUNT_LO +: 6];
      end
      if (hit_gain) begin
        gain_r <= pwdata[15:0];
      end
      if (hit_wrap) begin
        wrap_r <= pwdata[7:0];
      end
      if (hit_offs) begin
        offset_r <= pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // Curve tables, one word per entry; cleared at reset
  for (genvar gi = 0; gi < `Y_POINTS; gi++) begin : g_ytab
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ytab_r[gi] <= 13'h0;
      end else if (wr_en && hit_y && (tab_idx == 6'(gi))) begin
        ytab_r[gi] <= pwdata[12:0];
      end
    end
  end

  for (genvar gj = 0; gj < `X_POINTS; gj++) begin : g_xtab
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        xtab_r[gj] <= 6'h0;
      end else if (wr_en && hit_x && (tab_idx == 6'(gj))) begin
        xtab_r[gj] <= pwdata[5:0];  // RULE_18
      end
    end
  end

  // ==========================================================
  // Processing chain, combinational from sample to result flop
  logic [15:0] scaled_w;
  logic [15:0] offset_w;
  logic [15:0] curve_w;

  scale_offset_stage u_scale (
    .pre_scale_angle (pre_scale_angle),
    .cfg             (cfg),
    .scaled_angle    (scaled_w),
    .offset_angle    (offset_w)
  );

  curve_stage u_curve (
    .offset_angle (offset_w),
    .cfg          (cfg),
    .ytab         (ytab_r),
    .xtab         (xtab_r),
    .curve_angle  (curve_w)
  );

  // Result updates only on a new sample; valid is sample_valid delayed by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r       <= 16'h0;
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= sample_valid;   // RULE_23
      if (sample_valid) begin
        result_r <= curve_w;            // RULE_23
      end
    end
  end

  assign result_angle = result_r;
  assign result_valid = result_valid_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        seen_r;
  logic [63:0] full_prod;
  logic [63:0] off_sum;
  logic        above_chk;

  // Marks the first edge after reset for the default check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  // Reference values at full width, nothing truncated
  assign full_prod = (64'(pre_scale_angle) * 64'(gain_r)) >> 10;
  assign off_sum   = 64'(scaled_w) + {{47{offset_r[15]}}, offset_r, 1'b0};
  // Wrap test redone here so the checks do not lean on the stage
  assign above_chk = pre_scale_angle > {wrap_r, 8'h00};

  // A sample, then the loaded result one edge later
  sequence sample_taken;
    sample_valid;
  endsequence

  sequence result_loaded;
    result_valid && (result_angle == $past(curve_w));
  endsequence

  // Gain stage against the full-width reference product
  zero_gain_a: assert property (gain_r == 16'h0 && !above_chk |-> scaled_w == 16'h0) // RULE_01
    else $error("zero gain did not give zero angle");
  gain_wrap_a: assert property (!scale_clamp_r |-> scaled_w == full_prod[15:0]) // RULE_02
    else $error("unclamped gain did not wrap");
  clamp_sat_a: assert property (scale_clamp_r && !above_chk && full_prod > 64'hffff
                                |-> scaled_w == `ANGLE_TOP) // RULE_03
    else $error("clamped gain did not saturate");
  wrap_zero_a: assert property (scale_clamp_r && above_chk |-> scaled_w == 16'h0) // RULE_04
    else $error("angle past wrap point not zero");
  reset_default_a: assert property (!seen_r |-> scale_clamp_r && offset_clamp_r
                                    && wrap_r == 8'h0) // RULE_07
    else $error("configuration defaults wrong after reset");
  offset_clamp_a: assert property (offset_clamp_r && $signed(off_sum) > 64'sh0ffff
                                   |-> offset_w == `ANGLE_TOP) // RULE_08
    else $error("offset sum did not clamp high");
  bin_code_a: assert property (mode_r == 2'h1 |-> curve_w[2:0] == 3'h0) // RULE_15
    else $error("binning output not a 13-bit code");
  result_update_a: assert property (sample_taken |=> result_loaded) // RULE_23
    else $error("result not registered after sample");

  // ==========================================================
  // Offset stage: low limit, and the unclamped wrap; clamped gain passes an in-range angle
  offset_low_a: assert property (offset_clamp_r && $signed(off_sum) < 0
                                 |-> offset_w == 16'h0) // RULE_08
    else $error("offset sum did not clamp low");
  offset_wrap_a: assert property (!offset_clamp_r |-> offset_w == off_sum[15:0]) // RULE_08
    else $error("unclamped offset did not wrap");
  gain_pass_a: assert property (scale_clamp_r && !above_chk && full_prod <= 64'hffff
                                |-> scaled_w == full_prod[15:0]) // RULE_03
    else $error("clamped gain altered an in-range angle");

  // ==========================================================
  // Result flop holds between samples, valid stays low
  sequence sample_idle;
    !sample_valid;
  endsequence

  sequence result_held;
    !result_valid && $stable(result_angle);
  endsequence

  result_hold_a: assert property (sample_idle |=> result_held) // RULE_23
    else $error("result moved without a sample");

  // ==========================================================
  // Bus error only while an access phase stands
  bus_error_a: assert property (pslverr |-> psel && penable)
    else $error("bus error outside an access phase");
endmodule : angle_gain_offset_linearizer

/* logic/angle_curve_map.svh */
// Register offsets, field positions, reset values and limits of the angle stage
`ifndef ANGLE_CURVE_MAP_SVH
`define ANGLE_CURVE_MAP_SVH
// ==========================================================
// Register byte offsets
`define OFF_CTRL        12'h000
`define OFF_GAIN        12'h004
`define OFF_WRAP        12'h008
`define OFF_OFFSET      12'h00c
`define OFF_RESULT      12'h010
`define PAGE_YTAB       4'h1
`define PAGE_XTAB       4'h2
// ==========================================================
// Control register fields
`define CTRL_SCALE_CLAMP  0
`define CTRL_OFFS_CLAMP   1
`define CTRL_MODE_LO      2
`define CTRL_SPAN_LO      4
`define CTRL_COUNT_LO     6
// ==========================================================
// Reset values
`define RST_SCALE_CLAMP   1'b1
`define RST_OFFS_CLAMP    1'b1
`define RST_SPAN          2'h0
`define RST_COUNT         6'h21
`define RST_GAIN          16'h0400
`define RST_WRAP          8'h00
`define RST_OFFSET        16'h0000
// ==========================================================
// Table sizes and angle limits
`define Y_POINTS          33
`define X_POINTS          22
`define FIX_MAX_POINTS    6'h21
`define VLIN_MAX_POINTS   6'h16
`define VBIN_MAX_POINTS   6'h15
`define MIN_POINTS        6'h02
`define ANGLE_TOP         16'hffff
`endif

/* logic/angle_curve_pkg.sv */
// Types shared by the angle post-processing stages
package angle_curve_pkg;
  // ==========================================================
  // Transfer curve modes
  typedef enum logic [1:0] {
    FIXED_LIN,
    FIXED_BIN,
    VAR_LIN,
    VAR_BIN
  } curve_mode_t;

  // ==========================================================
  // Configuration bundle
  typedef struct packed {
    logic        scale_clamp_enable;
    logic        offset_clamp_enable;
    curve_mode_t mode;
    logic [1:0]  correction_span_select;
    logic [5:0]  point_count;
    logic [15:0] angle_scale_factor;
    logic [7:0]  clamp_wrap_point;
    logic [15:0] post_scale_offset;
  } cfg_t;

  typedef logic [32:0][12:0] ytab_t;
  typedef logic [21:0][5:0]  xtab_t;
endpackage : angle_curve_pkg

/* logic/scale_offset_stage.sv */
// Gain with wrap or clamp, then post-gain offset with wrap or clamp
`timescale 1ns/1ps
`include "angle_curve_map.svh"
module scale_offset_stage
  import angle_curve_pkg::*;
(
  input  wire logic [15:0] pre_scale_angle,
  input  wire cfg_t        cfg,
  output logic      [15:0] scaled_angle,
  output logic      [15:0] offset_angle
);
  // ==========================================================
  // Gain: 6.10 unsigned factor, zero factor gives zero product
  logic        [31:0] product;
  logic        [21:0] gained;
  logic               above_wrap;
  logic               overflow;
  logic signed [17:0] sum;

  assign product    = pre_scale_angle * cfg.angle_scale_factor;  // RULE_01
  assign gained     = product[31:10];  // RULE_02
  // Wrap point is compared in pre-gain units, step of 256 codes
  assign above_wrap = pre_scale_angle > {cfg.clamp_wrap_point, 8'h00};  // RULE_04
  assign overflow   = |gained[21:16];  // RULE_22
  // Zero above the wrap point takes priority over saturation
  assign scaled_angle = !cfg.scale_clamp_enable ? gained[15:0] :  // RULE_03
                        above_wrap              ? 16'h0000     :
                        overflow                ? `ANGLE_TOP   : gained[15:0];

  // ==========================================================
  // Offset: one code is two angle codes, sign extended
  assign sum = $signed({2'b00, scaled_angle}) +  // RULE_08
               $signed({cfg.post_scale_offset[15], cfg.post_scale_offset, 1'b0});
  assign offset_angle = !cfg.offset_clamp_enable ? sum[15:0]  :
                        sum[17]                  ? 16'h0000   :
                        sum[16]                  ? `ANGLE_TOP : sum[15:0];
endmodule : scale_offset_stage

/* logic/curve_stage.sv */
// Transfer curve: fixed or variable segments, linearization or binning
`timescale 1ns/1ps
`include "angle_curve_map.svh"
module curve_stage
  import angle_curve_pkg::*;
(
  input  wire logic [15:0] offset_angle,
  input  wire cfg_t        cfg,
  input  wire ytab_t       ytab,
  input  wire xtab_t       xtab,
  output logic      [15:0] curve_angle
);
  // Signed code to angle codes; code -4096 maps to plus the span
  function automatic logic signed [39:0] corr(input logic [12:0] code, input logic [1:0] sel);
    logic signed [39:0] c;
    c = 40'(signed'(code));
    corr = -(c <<< (32'd1 + 32'(sel)));  // RULE_11
  endfunction : corr

  // Results never wrap, they stick at the nearest end
  function automatic logic [15:0] clip(input logic signed [39:0] v);
    clip = (v < 0) ? 16'h0000 : (v > 40'sh0ffff) ? `ANGLE_TOP : v[15:0];  // RULE_13
  endfunction : clip

  // Point count held inside the legal range of each mode
  function automatic logic [5:0] limit(input logic [5:0] n, input logic [5:0] top);
    limit = (n < `MIN_POINTS) ? `MIN_POINTS : (n > top) ? top : n;
  endfunction : limit

  // ==========================================================
  // Fixed segments: position times segment count gives index and fraction
  logic        [5:0]  fix_n;
  logic        [21:0] fix_pos;
  logic        [4:0]  fix_idx;
  logic signed [39:0] fix_c0;
  logic signed [39:0] fix_c1;
  logic signed [39:0] fix_lin;

  assign fix_n   = limit(cfg.point_count, `FIX_MAX_POINTS) - 6'h01;
  assign fix_pos = offset_angle * fix_n;
  assign fix_idx = fix_pos[20:16];  // RULE_10
  assign fix_c0  = corr(ytab[fix_idx], cfg.correction_span_select);
  // Six-bit index: the top segment of a full table ends on entry 32
  assign fix_c1  = corr(ytab[6'(fix_idx) + 6'h01], cfg.correction_span_select);  // RULE_12
  assign fix_lin = fix_c0 + (((fix_c1 - fix_c0) * $signed({24'h0, fix_pos[15:0]})) >>> 16);

  // ==========================================================
  // Variable segments: count the positions at or below the input
  logic        [5:0]  vl_n;
  logic        [5:0]  vb_n;
  logic        [4:0]  vl_seg;
  logic        [4:0]  vb_cnt;
  logic        [15:0] x_lo;
  logic        [15:0] x_hi;
  logic signed [39:0] v_c0;
  logic signed [39:0] v_c1;
  logic signed [39:0] v_da;
  logic signed [39:0] v_dx;
  logic signed [39:0] var_lin;

  assign vl_n = limit(cfg.point_count, `VLIN_MAX_POINTS);
  assign vb_n = limit(cfg.point_count, `VBIN_MAX_POINTS);

  // Ordered positions let a plain count find the segment and the bin
  always_comb begin
    vl_seg = 5'h00;
    vb_cnt = 5'h00;
    for (int i = 0; i < `X_POINTS; i++) begin
      if (({xtab[i], 10'h000} <= offset_angle) && (i >= 1) && (i <= 32'(vl_n) - 2)) begin
        vl_seg = 5'(vl_seg + 5'h01);
      end
      if (({xtab[i], 10'h000} <= offset_angle) && (i < 32'(vb_n))) begin
        vb_cnt = 5'(vb_cnt + 5'h01);
      end
    end
  end

  // Outer segments extend their slope beyond the first and last points
  assign x_lo    = {xtab[vl_seg], 10'h000};  // RULE_20
  assign x_hi    = {xtab[5'(vl_seg + 5'h01)], 10'h000};  // RULE_21
  assign v_c0    = corr(ytab[vl_seg], cfg.correction_span_select);
  assign v_c1    = corr(ytab[5'(vl_seg + 5'h01)], cfg.correction_span_select);
  assign v_da    = $signed({24'h0, offset_angle}) - $signed({24'h0, x_lo});
  assign v_dx    = $signed({24'h0, x_hi}) - $signed({24'h0, x_lo});
  // Coincident points give a flat segment instead of a divide by zero
  assign var_lin = (v_dx == 40'sh0) ? v_c0 : v_c0 + ((v_c1 - v_c0) * v_da) / v_dx;

  // ==========================================================
  // Mode select; binning ignores the span select
  always_comb begin
    unique case (cfg.mode)  // RULE_09
      FIXED_LIN: curve_angle = clip($signed({24'h0, offset_angle}) + fix_lin);
      FIXED_BIN: curve_angle = {ytab[fix_idx], 3'h0};  // RULE_15 RULE_16
      VAR_LIN:   curve_angle = clip($signed({24'h0, offset_angle}) + var_lin);  // RULE_17
      VAR_BIN:   curve_angle = (vb_cnt == 5'h00) ? 16'h0000 :
                               {ytab[5'(vb_cnt - 5'h01)], 3'h0};
    endcase
  end
endmodule : curve_stage

/* testbench/angle_source_model.sv */
// Upstream angle source model: one angle per strobe, scrambled bus between strobes
`timescale 1ns/1ps
module angle_source_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic [15:0] req_angle,
  output logic             sample_valid,
  output logic      [15:0] pre_scale_angle
);
  logic [15:0] junk_r;
  // ==========================================================
  // Idle pattern
  // Changes every cycle so a stale angle can never pass for a fresh one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      junk_r <= 16'h0000;
    else
      junk_r <= {junk_r[14:0], ~junk_r[15]};
  end
  // Angle only means something while the strobe is up
  assign sample_valid    = req;
  assign pre_scale_angle = req ? req_angle : junk_r;
endmodule : angle_source_model

/* testbench/test_angle_gain_offset_linearizer.sv */
// Self-checking bench for the angle gain, offset and transfer curve block
`timescale 1ns/1ps
`include "angle_curve_map.svh"
module test_angle_gain_offset_linearizer import angle_curve_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        req, sample_valid, result_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] req_angle, pre_scale_angle, result_angle;
  logic        e;
  int          n_fail, n_compared, cycles;

  angle_gain_offset_linearizer angle_gain_offset_linearizer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pre_scale_angle(pre_scale_angle), .sample_valid(sample_valid),
    .result_angle(result_angle), .result_valid(result_valid));
  angle_source_model angle_source_model_i (
    .pclk(pclk), .presetn(presetn), .req(req), .req_angle(req_angle),
    .sample_valid(sample_valid), .pre_scale_angle(pre_scale_angle));

  // ==========================================================
  // Clock and hang guard
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========================================================
  // Compare and report
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t word got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_angle(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t angle got %h expected %h", $time, got, exp);
    end
  endtask : cmp_angle
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Bus master: request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    cmp_word(q, exp);
    cmp_word({31'h0, e}, {31'h0, exp_err});
  endtask : rd
  task automatic yw(input int i, input logic [12:0] c);
    wr({`PAGE_YTAB, 8'h00} + 12'(i * 4), {19'h0, c});
  endtask : yw
  task automatic xw(input int i, input logic [5:0] c);
    wr({`PAGE_XTAB, 8'h00} + 12'(i * 4), {26'h0, c});
  endtask : xw
  function automatic logic [31:0] ctrl(logic sc, logic oc, curve_mode_t m, logic [1:0] sp,
                                       logic [5:0] n);
    return ({31'h0, sc} << `CTRL_SCALE_CLAMP) | ({31'h0, oc} << `CTRL_OFFS_CLAMP)
         | ({30'h0, m} << `CTRL_MODE_LO) | ({30'h0, sp} << `CTRL_SPAN_LO)
         | ({26'h0, n} << `CTRL_COUNT_LO);
  endfunction : ctrl

  // ==========================================================
  // Sample path: strobe one cycle, result pulse exactly one cycle later
  task automatic samp(input logic [15:0] a, input logic [15:0] exp);
    @(posedge pclk);
    req       <= 1'b1;
    req_angle <= a;
    @(posedge pclk);
    req <= 1'b0;
    @(posedge pclk);
    cmp_word({31'h0, result_valid}, 32'h1);
    cmp_angle(result_angle, exp);
    @(posedge pclk);
    cmp_word({31'h0, result_valid}, 32'h0);
  endtask : samp

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    req = 1'b0;
    req_angle = 16'h0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Defaults, then an unmapped index past the table end
    rd(`OFF_CTRL, ctrl(1, 1, FIXED_LIN, 0, 6'h21), 1'b0);
    rd(`OFF_GAIN, 32'h400, 1'b0);
    rd(`OFF_WRAP, 32'h0, 1'b0);
    rd(`OFF_OFFSET, 32'h0, 1'b0);
    rd(12'h184, 32'h0, 1'b1);
    samp(16'h1234, 16'h0000);
    // Gain of four with the discontinuity at half turn plus half turn over gain
    wr(`OFF_GAIN, 32'h1000);
    wr(`OFF_WRAP, 32'ha0);
    samp(16'h1000, 16'h4000);
    samp(16'h4000, 16'hffff);
    samp(16'ha000, 16'hffff);
    samp(16'ha001, 16'h0000);
    wr(`OFF_CTRL, ctrl(0, 1, FIXED_LIN, 0, 6'h21));
    samp(16'h5000, 16'h4000);
    samp(16'hffff, 16'hfffc);
    wr(`OFF_GAIN, 32'h0);
    samp(16'h8000, 16'h0000);
    wr(`OFF_GAIN, 32'h401);
    samp(16'h8000, 16'h8020);
    // Post-gain offset, clamped and wrapped
    wr(`OFF_GAIN, 32'h400);
    wr(`OFF_WRAP, 32'hff);
    wr(`OFF_OFFSET, 32'h100);
    samp(16'h1000, 16'h1200);
    samp(16'hff00, 16'hffff);
    wr(`OFF_OFFSET, 32'hff00);
    samp(16'h0100, 16'h0000);
    wr(`OFF_CTRL, ctrl(1, 0, FIXED_LIN, 0, 6'h21));
    samp(16'h0100, 16'hff00);
    wr(`OFF_OFFSET, 32'h0);
    // Fixed linearization, every span, top clip on the widest
    yw(1, 13'h1000);
    for (int s = 0; s < 4; s++) begin
      wr(`OFF_CTRL, ctrl(1, 1, FIXED_LIN, 2'(s), 6'h02));
      samp(16'h8000, (s == 3) ? 16'hffff : 16'h8000 + (16'h1000 << s));
    end
    yw(0, 13'h0fff);
    yw(1, 13'h0000);
    wr(`OFF_CTRL, ctrl(1, 1, FIXED_LIN, 0, 6'h02));
    samp(16'h0100, 16'h0000);
    yw(0, 13'h0000);
    yw(1, 13'h0fff);
    wr(`OFF_CTRL, ctrl(1, 1, FIXED_LIN, 3, 6'h02));
    samp(16'h8000, 16'h0008);
    // Fixed binning: descending values, span left at its widest
    yw(0, 13'h1fff);
    yw(1, 13'h0005);
    wr(`OFF_CTRL, ctrl(1, 1, FIXED_BIN, 3, 6'h03));
    samp(16'h7fff, 16'hfff8);
    samp(16'h8000, 16'h0028);
    // Variable linearization with extrapolation at both ends
    xw(0, 6'd16);
    xw(1, 6'd32);
    xw(2, 6'd48);
    yw(0, 13'h0000);
    yw(1, 13'h1c00);
    yw(2, 13'h0000);
    wr(`OFF_CTRL, ctrl(1, 1, VAR_LIN, 0, 6'h03));
    samp(16'h6000, 16'h6400);
    samp(16'h4000, 16'h4000);
    samp(16'h2000, 16'h1c00);
    samp(16'he000, 16'hdc00);
    // Top segment of a full fixed table ends on entry 32
    yw(32, 13'h0fff);
    rd(12'h180, 32'h0fff, 1'b0);
    wr(`OFF_CTRL, ctrl(1, 1, FIXED_LIN, 0, 6'h21));
    samp(16'hfc00, 16'hec01);
    // Variable binning, then two samples back to back
    yw(0, 13'h0001);
    yw(1, 13'h0002);
    yw(2, 13'h0003);
    wr(`OFF_CTRL, ctrl(1, 1, VAR_BIN, 0, 6'h03));
    samp(16'h5000, 16'h0008);
    @(posedge pclk);
    req       <= 1'b1;
    req_angle <= 16'h9000;
    @(posedge pclk);
    req_angle <= 16'hc000;
    @(posedge pclk);
    req <= 1'b0;
    cmp_angle(result_angle, 16'h0010);
    @(posedge pclk);
    cmp_angle(result_angle, 16'h0018);
    cmp_word({31'h0, result_valid}, 32'h1);
    // Result register is read only; unmapped write is refused
    wr(`OFF_RESULT, 32'h1234);
    rd(`OFF_RESULT, 32'h18, 1'b0);
    apb(1'b1, 12'h0fc, 32'h5);
    cmp_word({31'h0, e}, 32'h1);
    print_verdict();
  end
endmodule : test_angle_gain_offset_linearizer
